// File: src/sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

// Bits in one serial byte
`define SPS_BITS_PER_BYTE 4'h8
// Width of the bit counter
`define SPS_CNT_W 4
// Reset levels of the synchronised select and serial clock
`define SPS_SEL_RST 1'b1
`define SPS_SCK_RST 1'b0

`endif

// File: src/sps_pkg.sv
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_IDLE   = 2'h0,
    SPS_ACTIVE = 2'h1,
    SPS_WAIT   = 2'h3
  } sps_state_t;
endpackage

// File: src/sps_sync.sv
`timescale 1ns/100ps
module sps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1_ff;
  logic stage2_ff;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
    end else begin
      stage1_ff <= i_async;
      stage2_ff <= stage1_ff;
    end
  end

  assign o_sync = stage2_ff;
endmodule

// File: src/sps_pin_ctrl.sv
// Behaviour
// - Enabled interface owns serial clock direction
// - Phase 1 accepts bytes with select held
// - Slave role: select always interface input
// - Slave fault only when fault detect enabled
// - Deselected slave tri-states data out
// - Deselected slave ignores serial clock edges
// - Master fault needs fault detect enable
// - Master without detect frees select pin
// - Master with detect: select input only
// - Disabled interface frees select pin
// - Select level always readable by port
// - Four flags, each gated onto interrupts
// - Master fault aborts and frees pins
// - Slave select high mid-transfer raises fault
// - Phase 1 starts on clock leaving idle
// - Fault clears by status read, control write
`timescale 1ns/100ps
`include "sps_defines.svh"
module sps_pin_ctrl (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_reset_n,
  // Configuration
  input  wire logic            i_iface_enable,
  input  wire logic            i_master_role_sel,
  input  wire logic            i_fault_detect_enable,
  input  wire logic            i_clock_phase_sel,
  input  wire logic            i_clock_polarity_sel,
  input  wire logic            i_error_irq_enable,
  input  wire logic            i_rx_irq_enable,
  input  wire logic            i_tx_irq_enable,
  // Flags from shift engine
  input  wire logic            i_rx_full_flag,
  input  wire logic            i_overflow_flag,
  input  wire logic            i_tx_empty_in,
  // Processor access strobes
  input  wire logic            i_status_read,
  input  wire logic            i_ctrl_write,
  // Shared port settings
  input  wire logic            i_port_dir_sel,
  input  wire logic            i_port_data_sel,
  input  wire logic            i_port_dir_sck,
  input  wire logic            i_port_data_sck,
  // Shift engine outputs
  input  wire logic            i_sck_engine_out,
  input  wire logic            i_miso_engine_out,
  // Pins
  input  wire logic            i_sel_pin,
  output logic                 o_sel_pin_out,
  output logic                 o_sel_pin_oe,
  input  wire logic            i_sck_pin,
  output logic                 o_sck_pin_out,
  output logic                 o_sck_pin_oe,
  output logic                 o_miso_out,
  output logic                 o_miso_oe,
  // Status and control outputs
  output logic                 o_sel_port_read,
  output logic                 o_contention_fault_flag,
  output logic                 o_tx_empty_flag,
  output logic                 o_iface_disable,
  output logic                 o_state_clear,
  output logic                 o_sck_sample,
  output logic                 o_sck_shift,
  output logic                 o_byte_done,
  output logic                 o_rx_irq,
  output logic                 o_tx_irq,
  output sps_pkg::sps_state_t  o_slave_state
);
  import sps_pkg::*;

  logic                  sel_s;
  logic                  sck_s;
  logic                  sck_prev_ff;
  logic                  leading;
  logic                  trailing;
  logic                  slave_en;
  logic                  master_fault;
  logic                  slave_fault;
  logic                  fault_cond;
  logic                  sel_owned;
  logic                  selected;
  sps_state_t            state_ff;
  sps_state_t            nxt_state;
  logic [`SPS_CNT_W-1:0] cnt_ff;
  logic [`SPS_CNT_W-1:0] nxt_cnt;
  logic                  sel_prev_ff;
  logic                  fault_ff;
  logic                  nxt_fault;
  logic                  armed_ff;
  logic                  nxt_armed;
  logic                  abort_ff;
  logic                  sample_ff;
  logic                  nxt_sample;
  logic                  shift_ff;
  logic                  nxt_shift;
  logic                  done_ff;
  logic                  nxt_done;
  logic                  txe_ff;

  // Pin synchronisers
  sps_sync #(.RST_VAL(`SPS_SEL_RST)) u_sel_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_sel_pin),
    .o_sync    (sel_s)
  );

  sps_sync #(.RST_VAL(`SPS_SCK_RST)) u_sck_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_async   (i_sck_pin),
    .o_sync    (sck_s)
  );

  // Clock edge detection against the idle level
  assign leading  = (sck_prev_ff == i_clock_polarity_sel) &&
                    (sck_s != i_clock_polarity_sel);
  assign trailing = (sck_prev_ff != i_clock_polarity_sel) &&
                    (sck_s == i_clock_polarity_sel);

  assign slave_en = i_iface_enable && !i_master_role_sel;
  assign selected = slave_en && !sel_s;

  // Fault conditions
  assign master_fault = i_iface_enable && i_master_role_sel &&
                        i_fault_detect_enable && !sel_s;
  assign slave_fault  = slave_en && i_fault_detect_enable &&
                        (state_ff == SPS_ACTIVE) && sel_s;
  assign fault_cond   = master_fault || slave_fault;

  // Pin ownership
  assign sel_owned = i_iface_enable && !abort_ff &&
                     (!i_master_role_sel || i_fault_detect_enable);
  assign o_sel_pin_oe  = sel_owned ? 1'b0 : i_port_dir_sel;
  assign o_sel_pin_out = i_port_data_sel;
  assign o_sel_port_read = sel_s;

  assign o_sck_pin_oe  = (i_iface_enable && !abort_ff) ?
                         i_master_role_sel : i_port_dir_sck;
  assign o_sck_pin_out = (i_iface_enable && !abort_ff) ?
                         i_sck_engine_out : i_port_data_sck;

  assign o_miso_oe  = selected;
  assign o_miso_out = i_miso_engine_out;

  // Slave framing
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_sample = 1'b0;
    nxt_shift  = 1'b0;
    nxt_done   = 1'b0;
    if (!slave_en) begin
      nxt_state = SPS_IDLE;
      nxt_cnt   = '0;
    end else begin
      unique case (state_ff)
        SPS_IDLE: begin
          nxt_cnt = '0;
          if (!i_clock_phase_sel && sel_prev_ff && !sel_s) begin
            nxt_state = SPS_ACTIVE;
          end else if (i_clock_phase_sel && !sel_s && leading) begin
            nxt_state  = SPS_ACTIVE;
            nxt_shift  = 1'b1;
          end
        end
        SPS_ACTIVE: begin
          if (sel_s) begin
            nxt_state = SPS_IDLE;
            nxt_cnt   = '0;
          end else begin
            nxt_sample = i_clock_phase_sel ? trailing : leading;
            nxt_shift  = i_clock_phase_sel ? leading : trailing;
            if (trailing) begin
              nxt_cnt = cnt_ff + 1'b1;
            end
            if (trailing && cnt_ff == `SPS_BITS_PER_BYTE - 1'b1) begin
              nxt_done  = 1'b1;
              nxt_cnt   = '0;
              nxt_state = i_clock_phase_sel ? SPS_IDLE : SPS_WAIT;
            end
          end
        end
        SPS_WAIT: begin
          if (sel_s) begin
            nxt_state = SPS_IDLE;
          end
        end
        default: begin
          nxt_state = SPS_IDLE;
        end
      endcase
    end
  end

  // Fault flag, set wins over clear
  always_comb begin
    nxt_fault = fault_ff;
    nxt_armed = armed_ff;
    if (i_status_read && fault_ff) begin
      nxt_armed = 1'b1;
    end
    if (i_ctrl_write && armed_ff && !fault_cond) begin
      nxt_fault = 1'b0;
      nxt_armed = 1'b0;
    end
    if (fault_cond) begin
      nxt_fault = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff    <= SPS_IDLE;
      cnt_ff      <= '0;
      sck_prev_ff <= `SPS_SCK_RST;
      sel_prev_ff <= `SPS_SEL_RST;
      fault_ff    <= 1'b0;
      armed_ff    <= 1'b0;
      abort_ff    <= 1'b0;
      sample_ff   <= 1'b0;
      shift_ff    <= 1'b0;
      done_ff     <= 1'b0;
      txe_ff      <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sck_prev_ff <= sck_s;
      sel_prev_ff <= sel_s;
      fault_ff    <= nxt_fault;
      armed_ff    <= nxt_armed;
      abort_ff    <= master_fault;
      sample_ff   <= nxt_sample;
      shift_ff    <= nxt_shift;
      done_ff     <= nxt_done;
      txe_ff      <= i_tx_empty_in || master_fault;
    end
  end

  assign o_contention_fault_flag = fault_ff;
  assign o_tx_empty_flag = txe_ff;
  assign o_iface_disable = abort_ff;
  assign o_state_clear   = abort_ff;
  assign o_sck_sample    = sample_ff;
  assign o_sck_shift     = shift_ff;
  assign o_byte_done     = done_ff;
  assign o_slave_state   = state_ff;

  // Interrupt requests from the four flags
  assign o_rx_irq = (i_rx_full_flag && i_rx_irq_enable) ||
                    ((i_overflow_flag || fault_ff) &&
                     i_error_irq_enable);
  assign o_tx_irq = txe_ff && i_tx_irq_enable;

  // Checks
  sck_dir_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_iface_enable && !abort_ff) |-> o_sck_pin_oe == i_master_role_sel)
    else $error("Serial clock direction not owned");

  cpha1_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (state_ff == SPS_ACTIVE && i_clock_phase_sel && nxt_done &&
     slave_en && !sel_s) |=> state_ff == SPS_IDLE)
    else $error("Phase 1 byte end did not rearm");

  slave_sel_in_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (slave_en && !abort_ff) |-> !o_sel_pin_oe)
    else $error("Slave select pin driven");

  miso_hiz_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (slave_en && sel_s) |-> !o_miso_oe)
    else $error("Data out driven while deselected");

  sck_ignore_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (slave_en && sel_s) |=> !o_sck_sample && !o_sck_shift)
    else $error("Clock edge passed while deselected");

  fault_gate_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(fault_ff) |-> $past(i_fault_detect_enable))
    else $error("Fault set without detect enable");

  master_gpio_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_iface_enable && i_master_role_sel && !i_fault_detect_enable)
      |-> o_sel_pin_oe == i_port_dir_sel)
    else $error("Select pin not released");

  off_gpio_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_iface_enable |-> o_sel_pin_oe == i_port_dir_sel)
    else $error("Disabled select pin not released");

  abort_seq_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    master_fault |=> o_iface_disable && o_tx_empty_flag && fault_ff)
    else $error("Master fault abort missing");

  slave_fault_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (slave_en && i_fault_detect_enable && state_ff == SPS_ACTIVE &&
     sel_s) |=> fault_ff)
    else $error("Slave deselect fault missed");

  fault_clear_a: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $fell(fault_ff) |-> $past(i_ctrl_write) && $past(armed_ff) &&
      !$past(fault_cond))
    else $error("Fault cleared without sequence");
endmodule

// File: tb/sps_ext_master.sv
`timescale 1ns/100ps
module sps_ext_master (
  // Link side
  input  wire logic i_pol,
  output logic      o_sel_n,
  output logic      o_sck
);
  initial begin
    o_sel_n = 1'b1;
    o_sck   = 1'b0;
  end

  // Select change, clock held at idle
  // Clock is parked at idle while the select still holds its old level,
  // and every pin change lands 1.5 ns after a rising bench clock edge, clear of both edges
  task automatic drive_sel(input logic v);
    #0.5 o_sck = i_pol;
    #100 o_sel_n = v;
    #99.5;
  endtask

  // Whole clock periods of 160 ns
  task automatic pulse_sck(input int n);
    #0.5 o_sck = i_pol;
    repeat (n) begin
      #80 o_sck = ~i_pol;
      #80 o_sck = i_pol;
    end
    #99.5;
  endtask
endmodule

// File: tb/spi_slave_select_pin_control_tb.sv
`timescale 1ns/100ps
module spi_slave_select_pin_control_tb;
  import sps_pkg::*;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %0t got %0h want %0h", \
    $time, (a), (e)); end end

  logic i_clk, i_reset_n, i_iface_enable, i_master_role_sel;
  logic i_fault_detect_enable, i_clock_phase_sel, i_clock_polarity_sel;
  logic i_error_irq_enable, i_rx_irq_enable, i_tx_irq_enable;
  logic i_rx_full_flag, i_overflow_flag, i_tx_empty_in;
  logic i_status_read, i_ctrl_write, i_port_dir_sel, i_port_data_sel;
  logic i_port_dir_sck, i_port_data_sck, i_sck_engine_out;
  logic i_miso_engine_out, i_sel_pin, i_sck_pin, p_sel, p_sck;
  logic o_sel_pin_out, o_sel_pin_oe, o_sck_pin_out, o_sck_pin_oe;
  logic o_miso_out, o_miso_oe, o_sel_port_read, o_contention_fault_flag;
  logic o_tx_empty_flag, o_iface_disable, o_state_clear, o_sck_sample;
  logic o_sck_shift, o_byte_done, o_rx_irq, o_tx_irq;
  sps_state_t o_slave_state;
  int checked, mismatches, n_smp, n_done, n_sft;
  // en mstr detect pdir pdata | sel_oe sel_out sck_oe
  logic [7:0] rows [7] = '{8'h1F, 8'h60, 8'h98, 8'hB0, 8'hDF, 8'hC1, 8'hF9};
  // en err_ie rx_ie tx_ie rx_full ovf txe sck_eng pdata_sck miso_eng |
  // rx_irq tx_irq sck_out miso_out
  logic [13:0] irq_rows [4] = '{14'h0E59, 14'h17AE, 14'h23D3, 14'h3C20};

  // Wire levels from the controller's enables, partner level otherwise
  assign i_sel_pin = o_sel_pin_oe ? o_sel_pin_out : p_sel;
  assign i_sck_pin = o_sck_pin_oe ? o_sck_pin_out : p_sck;

  sps_pin_ctrl dut_u (.*);
  sps_ext_master partner_u (
    .i_pol   (i_clock_polarity_sel),
    .o_sel_n (p_sel),
    .o_sck   (p_sck)
  );

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (o_sck_sample === 1'b1) n_smp++;
    if (o_byte_done === 1'b1) n_done++;
    if (o_sck_shift === 1'b1) n_sft++;
  end

  task automatic cfg(input logic en, m, fd, ph);
    @(posedge i_clk);
    i_iface_enable        <= en;
    i_master_role_sel     <= m;
    i_fault_detect_enable <= fd;
    i_clock_phase_sel     <= ph;
    i_port_dir_sck        <= 1'b0;
    i_port_dir_sel        <= 1'b0;
    // Phase 1 runs use an idle-high clock, phase 0 an idle-low one
    i_clock_polarity_sel  <= ph;
    #1;
  endtask

  task automatic settle();
    repeat (6) @(posedge i_clk);
    #1;
    n_smp = n_smp;
  endtask

  task automatic strobe(input bit rd);
    @(posedge i_clk);
    if (rd) i_status_read <= 1'b1;
    else i_ctrl_write <= 1'b1;
    @(posedge i_clk);
    i_status_read <= 1'b0;
    i_ctrl_write  <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {i_iface_enable, i_master_role_sel, i_fault_detect_enable} = 3'h0;
    {i_clock_phase_sel, i_clock_polarity_sel, i_rx_irq_enable} = 3'h0;
    {i_error_irq_enable, i_tx_irq_enable} = 2'h3;
    {i_rx_full_flag, i_overflow_flag, i_tx_empty_in} = 3'h0;
    {i_status_read, i_ctrl_write, i_port_dir_sel} = 3'h0;
    {i_port_data_sel, i_port_dir_sck, i_port_data_sck} = 3'h0;
    {i_sck_engine_out, i_miso_engine_out} = 2'h0;
    i_reset_n = 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (rows[k]) begin
      @(posedge i_clk);
      {i_iface_enable, i_master_role_sel, i_fault_detect_enable,
       i_port_dir_sel, i_port_data_sel} <= rows[k][7:3];
      i_port_dir_sck <= rows[k][4];
      settle();
      `CHK(o_sel_pin_oe, rows[k][2])
      if (rows[k][2]) `CHK(o_sel_pin_out, rows[k][1])
      `CHK(o_sck_pin_oe, rows[k][0])
      `CHK(o_contention_fault_flag, 1'b0)
      `CHK(o_sel_port_read, 1'b1)
    end
    $display("test table done");
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    n_smp = 0;
    n_done = 0;
    partner_u.drive_sel(1'b0);
    `CHK(o_miso_oe, 1'b1)
    `CHK(o_sel_port_read, 1'b0)
    partner_u.pulse_sck(8);
    `CHK(n_done, 1)
    `CHK(n_smp, 8)
    `CHK(o_slave_state, SPS_WAIT)
    partner_u.drive_sel(1'b1);
    `CHK(o_miso_oe, 1'b0)
    `CHK(o_contention_fault_flag, 1'b0)
    $display("test phase0 byte done");
    cfg(1'b1, 1'b0, 1'b1, 1'b1);
    n_done = 0;
    n_smp = 0;
    n_sft = 0;
    partner_u.drive_sel(1'b0);
    partner_u.pulse_sck(16);
    `CHK(n_done, 2)
    `CHK(n_sft, 16)
    `CHK(n_smp, 16)
    `CHK(o_slave_state, SPS_IDLE)
    partner_u.drive_sel(1'b1);
    `CHK(o_contention_fault_flag, 1'b0)
    $display("test phase1 held select done");
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    n_smp = 0;
    n_done = 0;
    partner_u.drive_sel(1'b0);
    partner_u.pulse_sck(3);
    partner_u.drive_sel(1'b1);
    partner_u.pulse_sck(5);
    `CHK(n_smp, 3)
    `CHK(n_done, 0)
    `CHK(o_contention_fault_flag, 1'b1)
    `CHK(o_rx_irq, 1'b1)
    strobe(1'b0);
    settle();
    `CHK(o_contention_fault_flag, 1'b1)
    strobe(1'b1);
    strobe(1'b0);
    settle();
    `CHK(o_contention_fault_flag, 1'b0)
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    partner_u.drive_sel(1'b0);
    partner_u.pulse_sck(3);
    partner_u.drive_sel(1'b1);
    `CHK(o_contention_fault_flag, 1'b0)
    $display("test slave abort done");
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    partner_u.drive_sel(1'b0);
    settle();
    `CHK(o_contention_fault_flag, 1'b0)
    cfg(1'b1, 1'b1, 1'b1, 1'b0);
    settle();
    `CHK(o_contention_fault_flag, 1'b1)
    `CHK(o_iface_disable, 1'b1)
    `CHK(o_tx_empty_flag, 1'b1)
    `CHK(o_sck_pin_oe, 1'b0)
    `CHK(o_tx_irq, 1'b1)
    `CHK(o_state_clear, 1'b1)
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    @(posedge i_clk);
    #1;
    `CHK(o_contention_fault_flag, 1'b0)
    `CHK(o_iface_disable, 1'b0)
    `CHK(o_tx_empty_flag, 1'b0)
    `CHK(o_sel_port_read, 1'b1)
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    #1;
    `CHK(o_sel_port_read, 1'b1)
    `CHK(o_contention_fault_flag, 1'b0)
    settle();
    `CHK(o_contention_fault_flag, 1'b1)
    `CHK(o_iface_disable, 1'b1)
    $display("test mid-run reset done");
    cfg(1'b0, 1'b1, 1'b1, 1'b0);
    partner_u.drive_sel(1'b1);
    settle();
    `CHK(o_iface_disable, 1'b0)
    `CHK(o_state_clear, 1'b0)
    $display("test master fault done");
    strobe(1'b1);
    strobe(1'b0);
    settle();
    `CHK(o_contention_fault_flag, 1'b0)
    foreach (irq_rows[k]) begin
      @(posedge i_clk);
      {i_iface_enable, i_error_irq_enable, i_rx_irq_enable, i_tx_irq_enable,
       i_rx_full_flag, i_overflow_flag, i_tx_empty_in, i_sck_engine_out,
       i_port_data_sck, i_miso_engine_out} <= irq_rows[k][13:4];
      settle();
      `CHK(o_rx_irq, irq_rows[k][3])
      `CHK(o_tx_irq, irq_rows[k][2])
      `CHK(o_tx_empty_flag, irq_rows[k][7])
      `CHK(o_sck_pin_out, irq_rows[k][1])
      `CHK(o_miso_out, irq_rows[k][0])
    end
    $display("test interrupts done");
    give_verdict();
  end
endmodule
